// ---- hw/ebcps_sequencer.sv ----
// module: five-phase external bus cycle sequencer with wait handshake
// Notes on behaviour
// - a bus cycle runs address, command delay, write setup, access, hold in order, stepping over zero-length command delay, write setup and hold
// - phase lengths come from a timing entry selected by the cycle's chip select
// - command 0..3, write setup 0..1, access 1..32, hold 0..3 timing units
// - address setup 1 or 2 units, plus 0..3 on window change, up to 5
// - with handshake enabled, the partner stretches access by keeping handshake inactive
// - pin transitions stay at least 12.5 ns apart by stretching the timing unit
// - reference clock passes the system clock when selected and fast driver enabled
// - handshake input polarity is selectable
// - asynchronous handshake takes an extra sync stage and at least one wait state
// - inactive sample adds a wait unit and resamples; active sample ends the access phase
module ebcps_sequencer (
	// clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 srst_i,
	// request from the bus controller core
	input  wire logic                 req_valid_i,
	input  wire ebcps_pkg::ebcps_req_t req_i,
	// timing configuration, one entry per chip select
	input  wire ebcps_pkg::ebcps_cfg_t cs_timing_i [ebcps_pkg::NUM_CS],
	input  wire logic [4:0]           unit_prescale_i,
	// reference clock output control
	input  wire logic                 external_clock_output_select_i,
	input  wire logic                 high_speed_driver_en_i,
	// handshake pin from the partner
	input  wire logic                 ready_pin_i,
	// bus pins and status
	output logic [ebcps_pkg::NUM_CS-1:0] cs_n_o,
	output logic                      ale_o,
	output logic                      rd_n_o,
	output logic                      wr_n_o,
	output logic                      wdata_oe_o,
	output logic                      read_latch_o,
	output logic                      done_o,
	output logic                      busy_o,
	output logic                      bus_reference_clock_en_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		ebcps_pkg::ebcps_phase_t phase;
		logic [5:0]              left;
		logic [4:0]              div;
		ebcps_pkg::ebcps_cfg_t   cfg;
		ebcps_pkg::ebcps_req_t   req;
		logic                    pending;
		logic                    waited;
		logic                    rdy_s1;
		logic                    rdy_s2;
		logic                    rdy_s3;
		ebcps_pkg::ebcps_pins_t  pins;
	} ebcps_state_t;

	ebcps_state_t st;
	ebcps_state_t next_st;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [5:0] ebcps_len(input ebcps_pkg::ebcps_phase_t ph,
			input ebcps_pkg::ebcps_cfg_t c, input logic win);
		logic [5:0] n;
		n = ebcps_pkg::LEN_ZERO;
		unique case (ph)
			ebcps_pkg::EBCPS_ADDR: begin
				n = ebcps_pkg::ADDR_BASE_UNITS + {5'h00, c.address_setup_long};
				if (win) begin
					n = n + {4'h0, c.window_change_extra};
				end
			end
			ebcps_pkg::EBCPS_CMD:    n = {4'h0, c.command_delay_length};
			ebcps_pkg::EBCPS_WSETUP: n = {5'h00, c.write_setup_tristate_length};
			ebcps_pkg::EBCPS_ACCESS: n = ebcps_pkg::ACCESS_BASE + {1'b0, c.access_length};
			ebcps_pkg::EBCPS_HOLD:   n = {4'h0, c.hold_length};
			ebcps_pkg::EBCPS_IDLE:   n = ebcps_pkg::LEN_ZERO;
		endcase
		return n;
	endfunction : ebcps_len

	// next phase in fixed order, stepping over any of zero length
	function automatic ebcps_pkg::ebcps_phase_t ebcps_step(input ebcps_pkg::ebcps_phase_t ph,
			input ebcps_pkg::ebcps_cfg_t c);
		ebcps_pkg::ebcps_phase_t p;
		p = ebcps_pkg::EBCPS_IDLE;
		unique case (ph)
			ebcps_pkg::EBCPS_IDLE:   p = ebcps_pkg::EBCPS_ADDR;
			ebcps_pkg::EBCPS_ADDR:   p = (c.command_delay_length != 2'h0) ? ebcps_pkg::EBCPS_CMD :
				(c.write_setup_tristate_length ? ebcps_pkg::EBCPS_WSETUP :
				ebcps_pkg::EBCPS_ACCESS);
			ebcps_pkg::EBCPS_CMD:    p = c.write_setup_tristate_length ? ebcps_pkg::EBCPS_WSETUP :
				ebcps_pkg::EBCPS_ACCESS;
			ebcps_pkg::EBCPS_WSETUP: p = ebcps_pkg::EBCPS_ACCESS;
			ebcps_pkg::EBCPS_ACCESS: p = (c.hold_length != 2'h0) ? ebcps_pkg::EBCPS_HOLD :
				ebcps_pkg::EBCPS_IDLE;
			ebcps_pkg::EBCPS_HOLD:   p = ebcps_pkg::EBCPS_IDLE;
		endcase
		return p;
	endfunction : ebcps_step

	// ****************************************************************
	// next state
	// ****************************************************************
	logic                    tick;
	logic [4:0]              unit_cyc;
	logic                    rdy_sample;
	logic                    rdy_active;
	logic                    unit_last;
	logic                    is_wr;
	ebcps_pkg::ebcps_phase_t nph;
	ebcps_pkg::ebcps_cfg_t   sel_cfg;

	always_comb begin
		next_st = st;
		sel_cfg = cs_timing_i[req_i.cs];
		// a unit never gets shorter than the least transition distance;
		// compared without the +1 so the largest prescale cannot wrap to zero
		unit_cyc = (unit_prescale_i < ebcps_pkg::MIN_GAP_CNT - 5'h01) ?
			ebcps_pkg::MIN_GAP_CNT - 5'h01 : unit_prescale_i;
		tick = (st.div == ebcps_pkg::DIV_RESET);
		next_st.div = tick ? unit_cyc : st.div - 5'h01;

		// the first stage only feeds the second; async mode reads one stage later
		next_st.rdy_s1 = ready_pin_i;
		next_st.rdy_s2 = st.rdy_s1;
		next_st.rdy_s3 = st.rdy_s2;
		rdy_sample = st.cfg.ready_async ? st.rdy_s3 : st.rdy_s2;
		rdy_active = rdy_sample ^ st.cfg.ready_active_low;

		next_st.pins.done       = 1'b0;
		next_st.pins.read_latch = 1'b0;
		next_st.pins.ref_clk_en = external_clock_output_select_i &
			high_speed_driver_en_i;

		if (req_valid_i && st.phase == ebcps_pkg::EBCPS_IDLE && !st.pending) begin
			next_st.pending = 1'b1;
			next_st.req     = req_i;
			next_st.cfg     = sel_cfg;
		end

		unit_last = (st.left == 6'h01);
		nph = st.phase;
		if (tick) begin
			unique case (st.phase)
				ebcps_pkg::EBCPS_IDLE: begin
					if (st.pending) begin
						nph             = ebcps_pkg::EBCPS_ADDR;
						next_st.pending = 1'b0;
						next_st.waited  = 1'b0;
						next_st.left    = ebcps_len(ebcps_pkg::EBCPS_ADDR, st.cfg,
							st.req.window_change);
					end
				end
				ebcps_pkg::EBCPS_ACCESS: begin
					if (!unit_last) begin
						next_st.left = st.left - 6'h01;
					end else if (st.cfg.ready_enable &&
							((st.cfg.ready_async && !st.waited) || !rdy_active)) begin
						// stay one more unit and resample
						next_st.waited = 1'b1;
					end else begin
						nph = ebcps_step(st.phase, st.cfg);
						next_st.pins.read_latch = !st.req.write;
					end
				end
				default: begin
					if (unit_last) begin
						nph = ebcps_step(st.phase, st.cfg);
					end else begin
						next_st.left = st.left - 6'h01;
					end
				end
			endcase
			if (nph != st.phase && st.phase != ebcps_pkg::EBCPS_IDLE) begin
				next_st.left = ebcps_len(nph, st.cfg, st.req.window_change);
				next_st.pins.done = (nph == ebcps_pkg::EBCPS_IDLE);
			end
			next_st.phase = nph;
		end

		// pin levels follow the phase being entered
		is_wr = next_st.req.write;
		next_st.pins.cs_n = {ebcps_pkg::NUM_CS{ebcps_pkg::CS_IDLE_LEVEL}};
		if (next_st.phase != ebcps_pkg::EBCPS_IDLE) begin
			next_st.pins.cs_n[next_st.req.cs] = ~ebcps_pkg::CS_IDLE_LEVEL;
		end
		next_st.pins.ale  = (next_st.phase == ebcps_pkg::EBCPS_ADDR);
		next_st.pins.rd_n = !(next_st.phase == ebcps_pkg::EBCPS_ACCESS && !is_wr);
		next_st.pins.wr_n = !(next_st.phase == ebcps_pkg::EBCPS_ACCESS && is_wr);
		// write data drives from write setup through hold; reads keep it tristate
		next_st.pins.wdata_oe = is_wr && (next_st.phase == ebcps_pkg::EBCPS_WSETUP ||
			next_st.phase == ebcps_pkg::EBCPS_ACCESS || next_st.phase == ebcps_pkg::EBCPS_HOLD);
		next_st.pins.busy = (next_st.phase != ebcps_pkg::EBCPS_IDLE) || next_st.pending;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st              <= '0;
			st.phase        <= ebcps_pkg::EBCPS_IDLE;
			st.div          <= ebcps_pkg::DIV_RESET;
			st.pins.cs_n    <= {ebcps_pkg::NUM_CS{ebcps_pkg::CS_IDLE_LEVEL}};
			st.pins.rd_n    <= 1'b1;
			st.pins.wr_n    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign cs_n_o                   = st.pins.cs_n;
	assign ale_o                    = st.pins.ale;
	assign rd_n_o                   = st.pins.rd_n;
	assign wr_n_o                   = st.pins.wr_n;
	assign wdata_oe_o               = st.pins.wdata_oe;
	assign read_latch_o             = st.pins.read_latch;
	assign done_o                   = st.pins.done;
	assign busy_o                   = st.pins.busy;
	assign bus_reference_clock_en_o = st.pins.ref_clk_en;
endmodule : ebcps_sequencer

// ---- shared/ebcps_pkg.sv ----
// package: constants, timing, state types for the external bus cycle phase sequencer
package ebcps_pkg;
	// ****************************************************************
	// sizes and timing
	// ****************************************************************
	localparam int unsigned NUM_CS          = 4;
	localparam int unsigned CLK_PERIOD_PS   = 100000;
	// least distance between two pin transitions
	localparam int unsigned MIN_GAP_PS      = 12500;
	localparam int unsigned MIN_GAP_CYC     =
		(MIN_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1 ? 1 :
		(MIN_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [4:0]  MIN_GAP_CNT     = 5'(MIN_GAP_CYC);
	localparam logic [5:0]  ADDR_BASE_UNITS = 6'h01;
	localparam logic [5:0]  ACCESS_BASE     = 6'h01;
	localparam logic [5:0]  LEN_ZERO        = 6'h00;
	localparam logic [4:0]  DIV_RESET       = 5'h00;
	localparam logic        CS_IDLE_LEVEL   = 1'b1;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		EBCPS_IDLE,
		EBCPS_ADDR,
		EBCPS_CMD,
		EBCPS_WSETUP,
		EBCPS_ACCESS,
		EBCPS_HOLD
	} ebcps_phase_t;

	// one chip_select_timing_config entry
	typedef struct packed {
		logic       address_setup_long;    // 0: 1 unit, 1: 2 units
		logic [1:0] window_change_extra;   // 0..3 extra units on window change
		logic [1:0] command_delay_length;  // 0..3
		logic       write_setup_tristate_length; // 0..1
		logic [4:0] access_length;         // 0..31 means 1..32 units
		logic [1:0] hold_length;           // 0..3
		logic       ready_enable;
		logic       ready_async;
		logic       ready_active_low;
	} ebcps_cfg_t;

	typedef struct packed {
		logic                      write;
		logic [$clog2(NUM_CS)-1:0] cs;
		logic                      window_change;
	} ebcps_req_t;

	typedef struct packed {
		logic [NUM_CS-1:0] cs_n;
		logic              ale;
		logic              rd_n;
		logic              wr_n;
		logic              wdata_oe;
		logic              read_latch;
		logic              done;
		logic              busy;
		logic              ref_clk_en;
	} ebcps_pins_t;
endpackage : ebcps_pkg

// ---- bench/ebcps_mem_model.sv ----
// partner model: external memory that answers the wait handshake
module ebcps_mem_model (
	// clock
	input  wire logic       clk_i,
	// bus commands
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	// behaviour
	input  wire logic       act_low_i,
	input  wire logic [5:0] delay_i,
	output logic            ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// wait handshake
	// ****************
	logic [5:0] cnt;
	always @(posedge clk_i) begin
		cnt <= (rd_n_i & wr_n_i) ? 6'h00 : ((cnt == 6'h3F) ? cnt : cnt + 6'h01);
	end
	// ready goes inactive with the command, long before the next cycle samples it
	assign ready_o = (!(rd_n_i & wr_n_i) && cnt >= delay_i) ^ act_low_i;
endmodule : ebcps_mem_model

// ---- bench/ebcps_sequencer_sva.sv ----
// checker: timing relations of the bus cycle phase sequencer pins
module ebcps_sequencer_sva (
	// clock and reset
	input wire logic                         core_clk_i,
	input wire logic                         srst_i,
	// controls
	input wire logic                         req_valid_i,
	input wire logic [4:0]                   unit_prescale_i,
	input wire logic                         external_clock_output_select_i,
	input wire logic                         high_speed_driver_en_i,
	// bus pins and status
	input wire logic [ebcps_pkg::NUM_CS-1:0] cs_n_o,
	input wire logic                         ale_o,
	input wire logic                         rd_n_o,
	input wire logic                         wr_n_o,
	input wire logic                         wdata_oe_o,
	input wire logic                         read_latch_o,
	input wire logic                         done_o,
	input wire logic                         busy_o,
	input wire logic                         bus_reference_clock_en_o
);
	// ****************
	// assertions
	// ****************
	logic [7:0] ale_run;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	always_ff @(posedge core_clk_i) begin
		ale_run <= (srst_i || !ale_o) ? 8'h00 : ale_run + 8'h01;
	end
	AST_START: assert property (req_valid_i && !busy_o |=> busy_o)
		else $error("request not taken while idle");
	AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> $past(req_valid_i))
		else $error("busy without a request");
	AST_IDLE: assert property (!busy_o |-> &cs_n_o && rd_n_o && wr_n_o && !ale_o && !wdata_oe_o)
		else $error("bus pins active while idle");
	AST_CS_ONE: assert property ($onehot0(~cs_n_o))
		else $error("more than one chip select");
	AST_ALE: assert property (ale_o |-> !(&cs_n_o) && rd_n_o && wr_n_o)
		else $error("address phase overlaps command");
	AST_CMD: assert property (!(rd_n_o && wr_n_o) |-> !ale_o && (rd_n_o || wr_n_o) && wdata_oe_o == !wr_n_o)
		else $error("command phase pins wrong");
	AST_LATCH: assert property ($rose(rd_n_o) == read_latch_o)
		else $error("read capture not at end of read access");
	AST_DONE: assert property (done_o |-> !busy_o && $past(busy_o) ##1 !done_o)
		else $error("done pulse wrong");
	AST_REF: assert property (!$past(srst_i) |-> bus_reference_clock_en_o ==
		$past(external_clock_output_select_i && high_speed_driver_en_i))
		else $error("reference clock enable wrong");
	AST_ADDR_MAX: assert property (ale_o |-> int'(ale_run) < 5 * (int'(unit_prescale_i) + 1))
		else $error("address phase too long");
	C_READ: cover property (read_latch_o);
	C_WRITE: cover property (!wr_n_o ##1 wr_n_o);
	C_REF: cover property (bus_reference_clock_en_o);
	C_WAIT: cover property (!rd_n_o [*8]);
endmodule : ebcps_sequencer_sva

// ---- bench/tb.sv ----
// testbench: bus cycle phase sequencer against a memory model
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// harness
	// ****************
	logic core_clk_i, srst_i, req_valid_i, sel, hs, ready, act_low;
	ebcps_pkg::ebcps_req_t req_i;
	ebcps_pkg::ebcps_cfg_t cfg [ebcps_pkg::NUM_CS];
	logic [4:0] pre;
	logic [5:0] dly;
	logic [3:0] cs_n, cs_seen;
	logic ale, rd_n, wr_n, oe, latch, done, busy, refen;
	logic [31:0] error_cnt, compares, n_len, n_ale, n_cmd, n_oe, n_lat, addr, units;
	ebcps_sequencer i_ebcps_sequencer (.core_clk_i, .srst_i, .req_valid_i, .req_i,
		.cs_timing_i(cfg), .unit_prescale_i(pre), .external_clock_output_select_i(sel),
		.high_speed_driver_en_i(hs), .ready_pin_i(ready), .cs_n_o(cs_n), .ale_o(ale),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .wdata_oe_o(oe), .read_latch_o(latch), .done_o(done),
		.busy_o(busy), .bus_reference_clock_en_o(refen));
	ebcps_mem_model i_ebcps_mem_model (.clk_i(core_clk_i), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.act_low_i(act_low), .delay_i(dly), .ready_o(ready));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		if (error_cnt === 32'h0 && compares !== 32'h0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	// holding the request for more than one cycle shows it is ignored while busy
	task automatic run(input logic wr, input logic [1:0] cs, input logic win, input int hold);
		int k;
		@(posedge core_clk_i);
		req_valid_i <= 1'b1;
		req_i <= '{wr, cs, win};
		{n_len, n_ale, n_cmd, n_oe, n_lat, cs_seen} = '0;
		// counting starts at the edge that takes the request, so no phase cycle is missed
		for (k = 0; k < 600; k++) begin
			@(posedge core_clk_i);
			if (k + 1 == hold) req_valid_i <= 1'b0;
			#1;
			n_len = n_len + 1;
			n_ale = n_ale + ale;
			n_cmd = n_cmd + !(rd_n & wr_n);
			n_oe = n_oe + oe;
			n_lat = n_lat + latch;
			cs_seen = cs_seen | ~cs_n;
			if (done === 1'b1) break;
		end
		if (k == 600) begin
			check(32'(k), 32'h0);
			complete_run();
		end
	endtask : run
	task automatic cycle(input logic wr, input logic [1:0] cs, input logic win, input int hold,
			input logic [31:0] lo);
		ebcps_pkg::ebcps_cfg_t c;
		logic [31:0] m, v;
		run(wr, cs, win, hold);
		c = cfg[cs];
		m = 32'(pre) + 1;
		addr = 1 + c.address_setup_long + (win ? c.window_change_extra : 2'h0);
		units = addr + c.command_delay_length + c.write_setup_tristate_length + c.hold_length;
		// one pending cycle, then 0..prescale clocks to the next unit tick, then the done cycle
		v = n_len - n_cmd - units * m;
		check(v >= 2 && v <= 1 + m, 1);
		check(n_ale, addr * m);
		if (lo == 0) check(n_cmd, (c.access_length + 1) * m);
		else check(n_cmd >= lo && n_cmd <= lo + 4, 1);
		check(n_oe, wr ? (units - addr - c.command_delay_length + c.access_length + 1) * m : 0);
		check(n_lat, !wr);
		check(cs_seen, 4'h1 << cs);
		@(posedge core_clk_i);
		#1;
		check(busy, 0);
		@(posedge core_clk_i);
	endtask : cycle
	// ****************
	// scenarios
	// ****************
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	initial begin
		{srst_i, req_valid_i, sel, hs, act_low, req_i, pre, error_cnt, compares} = '0;
		srst_i = 1'b1;
		dly = 6'h28;
		cfg[0] = '{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b0, 1'b0, 1'b0};
		cfg[1] = '{1'b1, 2'h3, 2'h3, 1'b1, 5'h1F, 2'h3, 1'b0, 1'b0, 1'b0};
		cfg[2] = '{1'b0, 2'h2, 2'h1, 1'b0, 5'h04, 2'h2, 1'b0, 1'b0, 1'b0};
		cfg[3] = '{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b1, 1'b0, 1'b0};
		repeat (5) @(posedge core_clk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 12; i++) cycle(i[0], 2'(i >> 2), i[1], 1, 0);
		cycle(1'b0, 2'h2, 1'b1, 2, 0);
		dly <= 6'h14;
		cycle(1'b0, 2'h3, 1'b0, 1, 21);
		act_low <= 1'b1;
		dly <= 6'h0C;
		cfg[3].ready_active_low <= 1'b1;
		cycle(1'b0, 2'h3, 1'b0, 1, 13);
		act_low <= 1'b0;
		dly <= 6'h00;
		cfg[3] <= '{1'b0, 2'h0, 2'h0, 1'b0, 5'h00, 2'h0, 1'b1, 1'b1, 1'b0};
		cycle(1'b0, 2'h3, 1'b0, 1, 2);
		pre <= 5'h02;
		cycle(1'b1, 2'h2, 1'b1, 1, 0);
		for (int i = 0; i < 4; i++) begin
			sel <= i[0];
			hs <= i[1];
			repeat (2) @(posedge core_clk_i);
			#1;
			check(refen, i[0] & i[1]);
			@(posedge core_clk_i);
		end
		complete_run();
	end
endmodule : tb

bind ebcps_sequencer ebcps_sequencer_sva i_ebcps_sequencer_sva (.core_clk_i, .srst_i,
	.req_valid_i, .unit_prescale_i, .external_clock_output_select_i, .high_speed_driver_en_i,
	.cs_n_o, .ale_o, .rd_n_o, .wr_n_o, .wdata_oe_o, .read_latch_o, .done_o, .busy_o,
	.bus_reference_clock_en_o);
